// [hw/cmcs_top.sv]
// Master mode control and status logic of the CAN controller with AXI4-Lite slave
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cmcs_top
  import cmcs_pkg::*;
#(
  parameter int BUSOFF_SEQS = CMCS_BOFF_SEQS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic can_rx,
  input wire logic bit_tick,
  input wire logic frame_busy,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic busoff_entry,
  input wire logic error_event,
  input wire logic fifo_full,
  input wire logic fifo_store_req,
  output logic fifo_store,
  output logic fifo_overwrite,
  output logic [3:0] policy,
  output logic [1:0] mode
);
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [3:0] flag_reg;
  logic [3:0] flag_next;
  logic [1:0] ien_reg;
  logic [1:0] ien_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  cmcs_mode_e mode_reg;
  cmcs_mode_e mode_next;
  logic sync_pend_reg;
  logic sync_pend_next;
  logic [7:0] boff_cnt_reg;
  logic [7:0] boff_cnt_next;
  logic recov_req;
  logic run_done;
  logic rx_prev_reg;
  logic sof_seen;
  logic aw_ok;
  logic w_ok;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] status_view;
  cmcs_policy_s pol;

  // Two-stage synchroniser for the receive pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= can_rx;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Falling edge on the synchronised line marks a start of frame
  assign sof_seen = rx_prev_reg && !rx_sync_reg;

  cmcs_recessive_counter #(
    .RUN_BITS(CMCS_IDLE_BITS)
  ) u_idle (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear((mode_reg == CMCS_SLEEP) || (mode_reg == CMCS_INIT) || (mode_next != mode_reg)),
    .bit_tick(bit_tick),
    .rx_level(rx_sync_reg),
    .run_done(run_done)
  );

  // Write channel acceptance: both address and data present
  assign aw_ok = s_axi_awvalid && !s_axi_bvalid && !s_axi_awready;
  assign w_ok = s_axi_wvalid && !s_axi_bvalid && !s_axi_wready;
  assign wr_fire = aw_ok && w_ok;
  assign wr_byte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
  assign recov_req = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == CMCS_OFF_RECOV) && s_axi_wdata[0];
  assign wr_hit = (s_axi_awaddr == CMCS_OFF_CTRL) || (s_axi_awaddr == CMCS_OFF_STAT) ||
                  (s_axi_awaddr == CMCS_OFF_IEN) || (s_axi_awaddr == CMCS_OFF_CFG) ||
                  (s_axi_awaddr == CMCS_OFF_RECOV);

  // Control, enable and configuration registers
  always_comb begin
    ctrl_next = ctrl_reg;
    ien_next = ien_reg;
    cfg_next = cfg_reg;
    if (wr_fire && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == CMCS_OFF_CTRL) begin
        ctrl_next = wr_byte & CMCS_CTRL_MASK;
      end
      if (s_axi_awaddr == CMCS_OFF_IEN) begin
        ien_next = wr_byte[1:0];
      end
      if ((s_axi_awaddr == CMCS_OFF_CFG) && (mode_reg == CMCS_INIT)) begin
        cfg_next = wr_byte;
      end
    end
    if ((mode_reg == CMCS_SLEEP) && ctrl_reg[CMCS_B_AWAKE] && sof_seen) begin
      ctrl_next[CMCS_B_SLEEP] = 1'b0;
    end
  end

  // Sticky flags: hardware set wins over write-one clear
  always_comb begin
    flag_next = flag_reg;
    if (wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == CMCS_OFF_STAT)) begin
      if (wr_byte[CMCS_S_WAKEUP_FLAG]) begin
        flag_next[CMCS_S_WAKEUP_FLAG] = 1'b0;
      end
      if (wr_byte[CMCS_S_ERROR_IRQ_FLAG]) begin
        flag_next[CMCS_S_ERROR_IRQ_FLAG] = 1'b0;
      end
    end
    if ((mode_reg == CMCS_SLEEP) && sof_seen) begin
      flag_next[CMCS_S_WAKEUP_FLAG] = 1'b1;
    end
    if (error_event) begin
      flag_next[CMCS_S_ERROR_IRQ_FLAG] = 1'b1;
    end
    flag_next[CMCS_S_INIT_ACK] = 1'b0;
    flag_next[CMCS_S_SLEEP_ACK] = 1'b0;
  end

  // Mode sequencing
  always_comb begin
    mode_next = mode_reg;
    sync_pend_next = sync_pend_reg;
    boff_cnt_next = boff_cnt_reg;
    case (mode_reg)
      CMCS_SLEEP: begin
        if (!ctrl_reg[CMCS_B_SLEEP]) begin
          mode_next = ctrl_reg[CMCS_B_INIT] ? CMCS_INIT : CMCS_NORMAL;
        end
      end
      CMCS_INIT: begin
        if (ctrl_reg[CMCS_B_SLEEP]) begin
          mode_next = CMCS_SLEEP;
        end else if (!ctrl_reg[CMCS_B_INIT]) begin
          mode_next = CMCS_NORMAL;
          sync_pend_next = 1'b1;
        end
      end
      CMCS_NORMAL: begin
        if (run_done) begin
          sync_pend_next = 1'b0;
        end
        if (busoff_entry) begin
          mode_next = CMCS_BUSOFF;
          boff_cnt_next = 8'h00;
        end else if (!frame_busy && ctrl_reg[CMCS_B_INIT]) begin
          mode_next = CMCS_INIT;
          sync_pend_next = 1'b0;
        end else if (!frame_busy && ctrl_reg[CMCS_B_SLEEP]) begin
          mode_next = CMCS_SLEEP;
          sync_pend_next = 1'b0;
        end
      end
      CMCS_BUSOFF: begin
        if (ctrl_reg[CMCS_B_AUTO_BUSOFF_RECOVERY] && run_done) begin
          if (boff_cnt_reg == 8'(BUSOFF_SEQS - 1)) begin
            mode_next = CMCS_NORMAL;
          end else begin
            boff_cnt_next = boff_cnt_reg + 8'h01;
          end
        end else if (!ctrl_reg[CMCS_B_AUTO_BUSOFF_RECOVERY] && recov_req) begin
          mode_next = CMCS_NORMAL;
        end
      end
      default: begin
        mode_next = CMCS_SLEEP;
      end
    endcase
  end

  // Policy outputs for the protocol engine
  always_comb begin
    pol.no_retransmit = ctrl_reg[CMCS_B_NORTX];
    pol.rx_fifo_lock = ctrl_reg[CMCS_B_FLOCK];
    pol.tx_order_select = ctrl_reg[CMCS_B_TXORD];
    pol.cfg_write_enable = (mode_reg == CMCS_INIT);
  end

  // Status byte with reserved bits at zero
  always_comb begin
    status_view = 8'h00;
    status_view[CMCS_S_INIT_ACK] = (mode_reg == CMCS_INIT) || sync_pend_reg;
    status_view[CMCS_S_SLEEP_ACK] = (mode_reg == CMCS_SLEEP);
    status_view[CMCS_S_ERROR_IRQ_FLAG] = flag_reg[CMCS_S_ERROR_IRQ_FLAG];
    status_view[CMCS_S_WAKEUP_FLAG] = flag_reg[CMCS_S_WAKEUP_FLAG];
    status_view[CMCS_S_TXA] = tx_active;
    status_view[CMCS_S_RXA] = rx_active;
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CMCS_OFF_CTRL: rd_word[7:0] = ctrl_reg;
      CMCS_OFF_STAT: rd_word[7:0] = status_view;
      CMCS_OFF_IEN: rd_word[1:0] = ien_reg;
      CMCS_OFF_CFG: rd_word[7:0] = cfg_reg;
      CMCS_OFF_RECOV: rd_word = 32'h0000_0000;
      default: rd_hit = 1'b0;
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CMCS_CTRL_RST;
      flag_reg <= 4'h0;
      ien_reg <= 2'b00;
      cfg_reg <= 8'h00;
      mode_reg <= CMCS_SLEEP;
      sync_pend_reg <= 1'b0;
      boff_cnt_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      cfg_reg <= cfg_next;
      mode_reg <= mode_next;
      sync_pend_reg <= sync_pend_next;
      boff_cnt_reg <= boff_cnt_next;
    end
  end

  // Receive FIFO store decision and registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_store <= 1'b0;
      fifo_overwrite <= 1'b0;
      policy <= 4'h0;
      mode <= CMCS_SLEEP;
    end else begin
      fifo_store <= fifo_store_req && !fifo_full;
      fifo_overwrite <= fifo_store_req && fifo_full && !ctrl_reg[CMCS_B_FLOCK];
      policy <= pol;
      mode <= mode_reg;
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CMCS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CMCS_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      if (wr_fire) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bresp <= wr_hit ? CMCS_RESP_OKAY : CMCS_RESP_SLVERR;
      end else if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1; // Response only after both channels were taken
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? CMCS_RESP_OKAY : CMCS_RESP_SLVERR;
      end else if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1; // Data only after the address was taken
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  sleep_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg == CMCS_SLEEP) |-> status_view[CMCS_S_SLEEP_ACK]) else $error("sleep ack missing");
  wake_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((mode_reg == CMCS_SLEEP) && sof_seen) |=> flag_reg[CMCS_S_WAKEUP_FLAG]) else $error("wake flag not set");
  err_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    error_event |=> flag_reg[CMCS_S_ERROR_IRQ_FLAG]) else $error("error flag not set");
  awake_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((mode_reg == CMCS_SLEEP) && ctrl_reg[CMCS_B_AWAKE] && sof_seen) |=> !ctrl_reg[CMCS_B_SLEEP]
    ##1 mode_reg != CMCS_SLEEP) else $error("auto wake failed");
  sleep_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((mode_reg == CMCS_SLEEP) && ctrl_reg[CMCS_B_SLEEP]) |=> (mode_reg == CMCS_SLEEP)) else $error("left sleep");
  busy_stay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((mode_reg == CMCS_NORMAL) && frame_busy && !busoff_entry) |=> (mode_reg == CMCS_NORMAL))
    else $error("mode left in frame");
  boff_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((mode_reg == CMCS_BUSOFF) && !ctrl_reg[CMCS_B_AUTO_BUSOFF_RECOVERY] && !recov_req) |=> (mode_reg == CMCS_BUSOFF))
    else $error("left bus-off");
  lock_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fifo_store_req && fifo_full && ctrl_reg[CMCS_B_FLOCK]) |=> !fifo_overwrite && !fifo_store)
    else $error("locked fifo overwritten");
  cfg_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg != CMCS_INIT) |=> $stable(cfg_reg)) else $error("config changed outside init");
  init_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg == CMCS_INIT) |-> status_view[CMCS_S_INIT_ACK]) else $error("init ack missing");
endmodule
`default_nettype wire

// [hw/cmcs_pkg.sv]
// Package with register map, field positions and timing constants of the CAN mode control block
package cmcs_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] CMCS_OFF_CTRL = 8'h00;
  localparam logic [7:0] CMCS_OFF_STAT = 8'h04;
  localparam logic [7:0] CMCS_OFF_IEN = 8'h08;
  localparam logic [7:0] CMCS_OFF_CFG = 8'h0C;
  localparam logic [7:0] CMCS_OFF_RECOV = 8'h10;
  // Master control fields
  localparam int CMCS_B_INIT = 0;
  localparam int CMCS_B_SLEEP = 1;
  localparam int CMCS_B_TXORD = 2;
  localparam int CMCS_B_FLOCK = 3;
  localparam int CMCS_B_NORTX = 4;
  localparam int CMCS_B_AWAKE = 5;
  localparam int CMCS_B_AUTO_BUSOFF_RECOVERY = 6;
  localparam logic [7:0] CMCS_CTRL_RST = 8'h02;
  localparam logic [7:0] CMCS_CTRL_MASK = 8'h7F;
  // Master status fields
  localparam int CMCS_S_INIT_ACK = 0;
  localparam int CMCS_S_SLEEP_ACK = 1;
  localparam int CMCS_S_ERROR_IRQ_FLAG = 2;
  localparam int CMCS_S_WAKEUP_FLAG = 3;
  localparam int CMCS_S_TXA = 4;
  localparam int CMCS_S_RXA = 5;
  // Interrupt enable fields
  localparam int CMCS_E_ERR = 0;
  localparam int CMCS_E_WKU = 1;
  // Bus timing and AXI response codes
  localparam int CMCS_IDLE_BITS = 11;
  localparam int CMCS_BOFF_SEQS = 128;
  localparam logic [1:0] CMCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CMCS_RESP_SLVERR = 2'b10;
  // Controller mode
  typedef enum logic [1:0] {
    CMCS_INIT = 2'b00,
    CMCS_NORMAL = 2'b01,
    CMCS_SLEEP = 2'b10,
    CMCS_BUSOFF = 2'b11
  } cmcs_mode_e;
  // Policy bits handed to the protocol engine
  typedef struct packed {
    logic no_retransmit;
    logic rx_fifo_lock;
    logic tx_order_select;
    logic cfg_write_enable;
  } cmcs_policy_s;
endpackage

// [hw/cmcs_recessive_counter.sv]
// Counter of consecutive recessive bits sampled on the receive line
`timescale 1ns/1ns
`default_nettype none
module cmcs_recessive_counter
  import cmcs_pkg::*;
#(
  parameter int RUN_BITS = CMCS_IDLE_BITS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic bit_tick,
  input wire logic rx_level,
  output logic run_done
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic run_done_next;

  // Count recessive samples, restart on dominant; pulse at run end
  always_comb begin
    cnt_next = cnt_reg;
    run_done_next = 1'b0;
    if (clear || (bit_tick && !rx_level)) begin
      cnt_next = 8'h00;
    end else if (bit_tick) begin
      if (cnt_reg == 8'(RUN_BITS - 1)) begin
        cnt_next = 8'h00;
        run_done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  // Register counter state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      run_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_done <= run_done_next;
    end
  end
endmodule
`default_nettype wire

// [dv/cmcs_can_node.sv]
// Model of the CAN bus seen through the line transceiver
`timescale 1ns/1ns
`default_nettype none
module cmcs_can_node #(
  parameter int BIT_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dom_req,
  output logic can_rx,
  output logic bit_tick
);
  logic [7:0] cnt_reg;
  // Bit timer; the terminated bus rests recessive between frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      can_rx <= 1'b1;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (cnt_reg == 8'(BIT_CYC - 1));
      if (cnt_reg == 8'(BIT_CYC - 1)) begin
        cnt_reg <= 8'h00;
        can_rx <= !dom_req; // Level changes only at bit boundaries
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/can_mode_control_status_tb.sv]
// Self-checking testbench of the CAN mode control and status block
`timescale 1ns/1ns
`default_nettype none
module can_mode_control_status_tb;
  import cmcs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb, policy;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode;
  logic can_rx, bit_tick, dom_req, frame_busy, rx_active, tx_active, busoff_entry, error_event;
  logic fifo_full, fifo_store_req, fifo_store, fifo_overwrite;
  logic [33:0] exp_q[$];
  logic [33:0] mon_exp;
  int bad_count = 0;
  int tests_run = 0;

  always #50 aclk = ~aclk;

  cmcs_top #(.BUSOFF_SEQS(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .can_rx(can_rx), .bit_tick(bit_tick), .frame_busy(frame_busy),
    .rx_active(rx_active), .tx_active(tx_active), .busoff_entry(busoff_entry),
    .error_event(error_event), .fifo_full(fifo_full), .fifo_store_req(fifo_store_req),
    .fifo_store(fifo_store), .fifo_overwrite(fifo_overwrite), .policy(policy), .mode(mode));

  cmcs_can_node #(.BIT_CYC(4)) u_node (.aclk(aclk), .aresetn(aresetn), .dom_req(dom_req),
    .can_rx(can_rx), .bit_tick(bit_tick));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] expv);
    tests_run++;
    if (seen !== expv) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write with address and data offered together; response noted for the monitor
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic bd;
    bd = 1'b0;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bd = s_axi_bvalid;
    end while (!bd);
    s_axi_bready <= 1'b0;
  endtask

  // Read whose expected data and response are noted for the monitor
  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic rd;
    rd = 1'b0;
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd = s_axi_rvalid;
    end while (!rd);
    s_axi_rready <= 1'b0;
  endtask

  // Monitor: every accepted response is matched with the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      mon_exp = exp_q.pop_front();
      check({s_axi_bresp, 32'h0000_0000}, mon_exp);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      mon_exp = exp_q.pop_front();
      if (mon_exp[33:32] == CMCS_RESP_OKAY) check({s_axi_rresp, s_axi_rdata}, mon_exp);
      else check({s_axi_rresp, 32'h0000_0000}, {mon_exp[33:32], 32'h0000_0000});
    end
  end

  // Store request with the FIFO level given, result checked one cycle later
  task automatic fifo_try(input logic full, input logic [1:0] expv);
    @(posedge aclk);
    fifo_full <= full;
    fifo_store_req <= 1'b1;
    @(posedge aclk);
    fifo_store_req <= 1'b0;
    @(posedge aclk);
    check(34'({fifo_store, fifo_overwrite}), 34'(expv));
  endtask

  // One dominant bit on the bus, seen as a start of frame
  task automatic sof();
    @(posedge aclk);
    dom_req <= 1'b1;
    cyc(4);
    dom_req <= 1'b0;
    cyc(20);
  endtask

  // Software side FIFO release waits for a dominant level or a long recessive run
  task automatic release_wait();
    int n;
    n = 0;
    while (can_rx && n <= 8) begin
      @(posedge aclk);
      if (bit_tick) n++;
    end
  endtask

  // Watchdog far beyond the expected run of about 820 cycles
  initial begin
    cyc(20000);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {dom_req, frame_busy, rx_active, tx_active, busoff_entry, error_event, fifo_full, fifo_store_req} = '0;
    rnd = 32'h0000_0033;
    cyc(12);
    aresetn <= 1'b1;
    axi_read(CMCS_OFF_CTRL, 32'h0000_0002, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_STAT, 32'h0000_0002, CMCS_RESP_OKAY);
    check(34'(mode), 34'(CMCS_SLEEP));
    axi_read(8'h14, 32'h0000_0000, CMCS_RESP_SLVERR);
    axi_write(8'h18, 32'h0000_00FF, CMCS_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    axi_write(CMCS_OFF_CTRL, 32'h0000_00FF, CMCS_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(CMCS_OFF_CTRL, 32'h0000_0002, CMCS_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      axi_write(CMCS_OFF_IEN, rnd, CMCS_RESP_OKAY);
      axi_read(CMCS_OFF_IEN, rnd & 32'h0000_0003, CMCS_RESP_OKAY);
    end
    $display("test reset and register map done");
    axi_write(CMCS_OFF_CTRL, 32'h0000_001D, CMCS_RESP_OKAY);
    cyc(4);
    check(34'(mode), 34'(CMCS_INIT));
    check(34'(policy), 34'h0_0000_000F);
    axi_read(CMCS_OFF_STAT, 32'h0000_0001, CMCS_RESP_OKAY);
    fifo_try(1'b1, 2'b00);
    release_wait();
    fifo_try(1'b0, 2'b10);
    rnd = xs(rnd);
    axi_write(CMCS_OFF_CFG, rnd, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_CFG, rnd & 32'h0000_00FF, CMCS_RESP_OKAY);
    $display("test init entry done");
    axi_write(CMCS_OFF_CTRL, 32'h0000_0000, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_STAT, 32'h0000_0001, CMCS_RESP_OKAY);
    cyc(80);
    axi_read(CMCS_OFF_STAT, 32'h0000_0000, CMCS_RESP_OKAY);
    check(34'(mode), 34'(CMCS_NORMAL));
    check(34'(policy), 34'h0_0000_0000);
    axi_write(CMCS_OFF_CFG, rnd ^ 32'h0000_00FF, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_CFG, rnd & 32'h0000_00FF, CMCS_RESP_OKAY);
    fifo_try(1'b1, 2'b01);
    $display("test init exit done");
    @(posedge aclk);
    rx_active <= 1'b1;
    tx_active <= 1'b1;
    axi_read(CMCS_OFF_STAT, 32'h0000_0030, CMCS_RESP_OKAY);
    rx_active <= 1'b0;
    tx_active <= 1'b0;
    error_event <= 1'b1;
    @(posedge aclk);
    error_event <= 1'b0;
    axi_read(CMCS_OFF_STAT, 32'h0000_0004, CMCS_RESP_OKAY);
    axi_write(CMCS_OFF_STAT, 32'h0000_0000, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_STAT, 32'h0000_0004, CMCS_RESP_OKAY);
    axi_write(CMCS_OFF_STAT, 32'h0000_0004, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_STAT, 32'h0000_0000, CMCS_RESP_OKAY);
    $display("test status flags done");
    frame_busy <= 1'b1;
    axi_write(CMCS_OFF_CTRL, 32'h0000_0002, CMCS_RESP_OKAY);
    cyc(10);
    check(34'(mode), 34'(CMCS_NORMAL));
    frame_busy <= 1'b0;
    cyc(4);
    check(34'(mode), 34'(CMCS_SLEEP));
    sof();
    check(34'(mode), 34'(CMCS_SLEEP));
    axi_read(CMCS_OFF_STAT, 32'h0000_000A, CMCS_RESP_OKAY);
    axi_write(CMCS_OFF_STAT, 32'h0000_0008, CMCS_RESP_OKAY);
    axi_write(CMCS_OFF_CTRL, 32'h0000_0022, CMCS_RESP_OKAY);
    sof();
    check(34'(mode), 34'(CMCS_NORMAL));
    axi_read(CMCS_OFF_CTRL, 32'h0000_0020, CMCS_RESP_OKAY);
    axi_read(CMCS_OFF_STAT, 32'h0000_0008, CMCS_RESP_OKAY);
    axi_write(CMCS_OFF_STAT, 32'h0000_0008, CMCS_RESP_OKAY);
    $display("test sleep and wake-up done");
    axi_write(CMCS_OFF_CTRL, 32'h0000_0040, CMCS_RESP_OKAY);
    busoff_entry <= 1'b1;
    @(posedge aclk);
    busoff_entry <= 1'b0;
    cyc(40);
    check(34'(mode), 34'(CMCS_BUSOFF));
    cyc(120);
    check(34'(mode), 34'(CMCS_NORMAL));
    axi_write(CMCS_OFF_CTRL, 32'h0000_0000, CMCS_RESP_OKAY);
    busoff_entry <= 1'b1;
    @(posedge aclk);
    busoff_entry <= 1'b0;
    cyc(200);
    check(34'(mode), 34'(CMCS_BUSOFF));
    axi_write(CMCS_OFF_RECOV, 32'h0000_0001, CMCS_RESP_OKAY);
    cyc(100);
    check(34'(mode == CMCS_BUSOFF), 34'h0);
    $display("test bus-off recovery done");
    end_sim();
  end
endmodule
`default_nettype wire
